// *** hw/intc_pkg.sv ***
// How it works
// - A request bit reads one while its line is pending, zero otherwise.
// - Sixty-four request words of thirty-two bits give 2048 request lines.
// - Bit b of request word x shows request line 32*x+b.
// - Request words follow the lines continuously and ignore bus writes.
// - Request words sit in ascending group order up to byte address 0x1FC.
// - Each level has a cause word naming the best pending group at that level.
// - A cause value matters only while its level has a pending request.
// - Four read-only cause words at 0x200 to 0x20C, group in low bits.
// - All lines of a group share one handler offset and one level.
// - The register side runs on the bus interface clock.
// - Lines follow a fixed map over groups 0 to 30; others stay idle.
// - Level field runs from 0 lowest to 3 highest.
// - Among groups at the top pending level, the lowest group number wins.
// - A pending non-maskable request beats every other request.
// - A request reaches the core three clock cycles after it rises.
`default_nettype none
package intc_pkg;
	localparam int          NUM_GROUPS      = 64;
	localparam int          LINES_PER_GROUP = 32;
	localparam int          NUM_LINES       = NUM_GROUPS * LINES_PER_GROUP;
	localparam int          GROUP_W         = 6;
	localparam int          VEC_W           = 14;
	localparam int          NUM_LEVELS      = 4;
	localparam int          ADDR_W          = 10;
	// Byte addresses of the three register banks.
	localparam logic [9:0]  PRIO_BASE       = 10'h000;
	localparam logic [9:0]  PEND_BASE       = 10'h100;
	localparam logic [9:0]  PEND_LAST       = 10'h1FC;
	localparam logic [9:0]  CAUSE_BASE      = 10'h200;
	localparam logic [9:0]  CAUSE_LAST      = 10'h20C;
	// Field positions inside a priority word.
	localparam int          LEVEL_MSB       = 31;
	localparam int          LEVEL_LSB       = 30;
	localparam logic [1:0]  LEVEL_RESET     = 2'h0;
	localparam logic [13:0] VEC_RESET       = 14'h0000;
	localparam logic [1:0]  NMI_LEVEL       = 2'h3;
	localparam int          CORE_LATENCY    = 3;

	// Lines that are wired to a source in each group.
	function automatic logic [31:0] group_line_mask(input int g);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (g == 1) begin
			m = 32'h0000_0003;
		end else if (g == 4 || g == 5 || g == 6 || g == 10 || g == 11) begin
			m = 32'h0000_000F;
		end else if (g == 14) begin
			m = 32'h0000_00FF;
		end else if (g == 25 || g == 26) begin
			m = 32'h0000_0007;
		end else if (g <= 30) begin
			m = 32'h0000_0001;
		end
		return m;
	endfunction : group_line_mask

	// Mask over all request lines built from the per-group map.
	function automatic logic [NUM_LINES-1:0] all_line_mask();
		logic [NUM_LINES-1:0] m;
		m = '0;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			m[g*LINES_PER_GROUP +: LINES_PER_GROUP] = group_line_mask(g);
		end
		return m;
	endfunction : all_line_mask

	// Lowest numbered set bit of a group vector.
	function automatic logic [5:0] lowest_group(input logic [63:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 63; i >= 0; i--) begin
			if (v[i]) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction : lowest_group
endpackage : intc_pkg
`default_nettype wire

// *** hw/level_prioritizer.sv ***
`default_nettype none
module level_prioritizer
	import intc_pkg::*;
(
	input  wire logic                    [63:0] group_request,
	input  wire logic [63:0]             [1:0]  group_level,
	input  wire logic                           global_mask,
	input  wire logic                    [3:0]  level_mask,
	output logic      [3:0]              [63:0] level_hits,
	output logic      [3:0]              [5:0]  level_cause,
	output logic                         [3:0]  valid_any,
	output logic                                sel_valid,
	output logic                         [1:0]  sel_level,
	output logic                         [5:0]  sel_group
);
	// Sort pending groups by level and pick the lowest group at each level.
	always_comb begin
		for (int n = 0; n < NUM_LEVELS; n++) begin
			for (int g = 0; g < NUM_GROUPS; g++) begin
				level_hits[n][g] = group_request[g] && (group_level[g] == 2'(n));
			end
			level_cause[n] = lowest_group(level_hits[n]);
			valid_any[n]   = (|level_hits[n]) && !level_mask[n] && !global_mask;
		end
	end

	// Highest unmasked level wins; level 3 is the top.
	always_comb begin
		sel_valid = 1'b0;
		sel_level = 2'h0;
		for (int n = 0; n < NUM_LEVELS; n++) begin
			if (valid_any[n]) begin
				sel_valid = 1'b1;
				sel_level = 2'(n);
			end
		end
		sel_group = level_cause[sel_level];
	end
endmodule : level_prioritizer
`default_nettype wire

// *** hw/grouped_intc.sv ***
// The Avalon-MM interface to the registers was decided locally.
`default_nettype none
module grouped_intc
	import intc_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic [ADDR_W-1:0]    address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	input  wire logic [3:0]           byteenable,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	input  wire logic [NUM_LINES-1:0] irq_lines,
	input  wire logic                 nmi_req,
	input  wire logic                 core_global_mask,
	input  wire logic [3:0]           core_level_mask,
	output logic                      core_req,
	output logic                      core_nmi,
	output logic      [1:0]           core_level,
	output logic      [VEC_W-1:0]     core_autovector
);
	localparam logic [NUM_LINES-1:0] LINE_MAP = all_line_mask();

	////////////////////////////////////////////////////////////////////////////////
	// Request line sampling.

	logic [NUM_LINES-1:0] line_meta;
	logic [NUM_LINES-1:0] pending_line_reg;
	logic                 nmi_meta;
	logic                 nmi_sync;

	// Unwired lines are gated off at the pin so they never reach the first flop.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			line_meta        <= '0;
			pending_line_reg <= '0;
			nmi_meta         <= 1'b0;
			nmi_sync         <= 1'b0;
		end else begin
			line_meta        <= irq_lines & LINE_MAP;
			pending_line_reg <= line_meta;
			nmi_meta         <= nmi_req;
			nmi_sync         <= nmi_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Group requests and prioritizing.

	logic [63:0]        group_request;
	logic [63:0][1:0]   prio_level;
	logic [63:0][13:0]  prio_vec;
	logic [3:0][63:0]   level_hits;
	logic [3:0][5:0]    level_cause;
	logic [3:0]         valid_any;
	logic               sel_valid;
	logic [1:0]         sel_level;
	logic [5:0]         sel_group;

	// Each group request is the OR of all its lines.
	always_comb begin
		for (int g = 0; g < NUM_GROUPS; g++) begin
			group_request[g] = |pending_line_reg[g*LINES_PER_GROUP +: LINES_PER_GROUP];
		end
	end

	level_prioritizer u_prio (
		.group_request (group_request),
		.group_level   (prio_level),
		.global_mask   (core_global_mask),
		.level_mask    (core_level_mask),
		.level_hits    (level_hits),
		.level_cause   (level_cause),
		.valid_any     (valid_any),
		.sel_valid     (sel_valid),
		.sel_level     (sel_level),
		.sel_group     (sel_group)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Core side and cause registers.

	logic [3:0][5:0]   cause_q;
	logic [3:0][5:0]   next_cause_q;
	logic              next_core_req;
	logic              next_core_nmi;
	logic [1:0]        next_core_level;
	logic [VEC_W-1:0]  next_core_autovector;

	// The non-maskable request overrides any group and carries no handler offset.
	always_comb begin
		next_cause_q         = level_cause;
		next_core_nmi        = nmi_sync;
		next_core_req        = nmi_sync || sel_valid;
		next_core_level      = sel_level;
		next_core_autovector = prio_vec[sel_group];
		if (nmi_sync) begin
			next_core_level      = NMI_LEVEL;
			next_core_autovector = VEC_RESET;
		end
	end

	// Third stage of the request path toward the core.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cause_q         <= '0;
			core_req        <= 1'b0;
			core_nmi        <= 1'b0;
			core_level      <= 2'h0;
			core_autovector <= VEC_RESET;
		end else begin
			cause_q         <= next_cause_q;
			core_req        <= next_core_req;
			core_nmi        <= next_core_nmi;
			core_level      <= next_core_level;
			core_autovector <= next_core_autovector;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle on every access.

	logic              wait_q;
	logic              next_wait_q;
	logic [31:0]       next_readdata;
	logic              take_write;
	logic [63:0][1:0]  next_prio_level;
	logic [63:0][13:0] next_prio_vec;
	logic [5:0]        word_idx;
	logic [ADDR_W-1:0] word_addr;

	// The byte offset inside a word selects nothing; byteenable picks which fields a write takes.
	assign word_addr  = {address[ADDR_W-1:2], 2'h0};
	assign word_idx   = address[7:2];
	assign take_write = write && !wait_q;
	assign waitrequest = wait_q;

	// Read data are built during the wait cycle from the word that is addressed.
	always_comb begin
		next_wait_q   = 1'b1;
		next_readdata = readdata;
		if ((read || write) && wait_q) begin
			next_wait_q   = 1'b0;
			next_readdata = 32'h0000_0000;
			if (read && word_addr < PEND_BASE) begin
				next_readdata[LEVEL_MSB:LEVEL_LSB] = prio_level[word_idx];
				next_readdata[VEC_W-1:0]           = prio_vec[word_idx];
			end else if (read && word_addr <= PEND_LAST) begin
				next_readdata = pending_line_reg[word_idx*LINES_PER_GROUP +: LINES_PER_GROUP];
			end else if (read && word_addr >= CAUSE_BASE && word_addr <= CAUSE_LAST) begin
				next_readdata[GROUP_W-1:0] = cause_q[2'h3 - address[3:2]];
			end
		end
	end

	// Only the priority words take writes; the other banks ignore them.
	always_comb begin
		next_prio_level = prio_level;
		next_prio_vec   = prio_vec;
		if (take_write && word_addr < PEND_BASE) begin
			if (byteenable[3]) begin
				next_prio_level[word_idx] = writedata[LEVEL_MSB:LEVEL_LSB];
			end
			if (byteenable[1]) begin
				next_prio_vec[word_idx][13:8] = writedata[13:8];
			end
			if (byteenable[0]) begin
				next_prio_vec[word_idx][7:0] = writedata[7:0];
			end
		end
	end

	// Bus handshake and priority storage.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_q     <= 1'b1;
			readdata   <= 32'h0000_0000;
			prio_level <= {NUM_GROUPS{LEVEL_RESET}};
			prio_vec   <= {NUM_GROUPS{VEC_RESET}};
		end else begin
			wait_q     <= next_wait_q;
			readdata   <= next_readdata;
			prio_level <= next_prio_level;
			prio_vec   <= next_prio_vec;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [63:0] exp_pend_word;
	logic [63:0] lower_groups;
	logic [3:0]  higher_levels;

	assign exp_pend_word = 64'(pending_line_reg[word_idx*LINES_PER_GROUP +: LINES_PER_GROUP]);
	assign lower_groups  = (64'h0000_0000_0000_0001 << level_cause[3]) - 64'h0000_0000_0000_0001;
	assign higher_levels = 4'(valid_any >> (3'(sel_level) + 3'h1));

	AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (rst)
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("Access was not answered after one wait cycle.");

	AST_RD_PEND: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && address >= PEND_BASE && address <= PEND_LAST
		|=> 64'(readdata) == $past(exp_pend_word))
		else $error("Request word read back wrong.");

	AST_CAUSE_RESVD: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && address >= CAUSE_BASE |=> readdata[31:GROUP_W] == 26'h000_0000)
		else $error("Cause word upper bits not zero.");

	AST_RO_WRITE: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && address >= PEND_BASE |=> $stable(prio_level) && $stable(prio_vec))
		else $error("Write to read-only word changed state.");

	AST_LOWEST: assert property (@(posedge mclk) disable iff (rst)
		|level_hits[3] |-> level_hits[3][level_cause[3]] && !(|(level_hits[3] & lower_groups)))
		else $error("Cause does not name lowest pending group.");

	AST_TOP_LEVEL: assert property (@(posedge mclk) disable iff (rst)
		sel_valid |-> valid_any[sel_level] && higher_levels == 4'h0)
		else $error("Selected level is not the highest unmasked one.");

	AST_NMI_WINS: assert property (@(posedge mclk) disable iff (rst)
		nmi_sync |=> core_req && core_nmi && core_level == NMI_LEVEL)
		else $error("Non-maskable request not forwarded.");

	AST_LATENCY: assert property (@(posedge mclk) disable iff (rst)
		sel_valid && !nmi_sync |=> core_req && core_autovector == $past(prio_vec[sel_group]))
		else $error("Group request not forwarded in time.");

	AST_MAP: assert property (@(posedge mclk) disable iff (rst)
		(pending_line_reg & ~LINE_MAP) == '0)
		else $error("Unwired request line seen as pending.");

	// Idle bus keeps the slave stalled until a request arrives.
	AST_WAIT_IDLE: assert property (@(posedge mclk) disable iff (rst)
		!read && !write |=> waitrequest)
		else $error("Slave left waitrequest low while idle.");

	// Read data move only at the edge that ends the wait cycle of an access.
	AST_RD_HOLD: assert property (@(posedge mclk) disable iff (rst)
		!((read || write) && waitrequest) |=> $stable(readdata))
		else $error("Read data changed outside an access.");

	// A level written to a priority word is stored.
	AST_PRIO_STORE: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && word_addr < PEND_BASE && byteenable[3]
		|=> prio_level[$past(word_idx)] == $past(writedata[LEVEL_MSB:LEVEL_LSB]))
		else $error("Priority level not stored.");

	// A handler offset written to a priority word is stored.
	AST_VEC_STORE: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && word_addr < PEND_BASE && (&byteenable[1:0])
		|=> prio_vec[$past(word_idx)] == $past(writedata[VEC_W-1:0]))
		else $error("Handler offset not stored.");

	// The level 2 cause names a group that is pending at level 2.
	AST_CAUSE_HIT: assert property (@(posedge mclk) disable iff (rst)
		|level_hits[2] |-> level_hits[2][level_cause[2]])
		else $error("Level 2 cause names an idle group.");

	// The level 3 cause word returns the registered cause.
	AST_CAUSE_READ: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr == CAUSE_BASE
		|=> readdata[GROUP_W-1:0] == $past(cause_q[3]))
		else $error("Level 3 cause read back wrong.");

	// Words past the cause bank read as zero.
	AST_UNMAPPED: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr > CAUSE_LAST |=> readdata == 32'h0000_0000)
		else $error("Unmapped word did not read zero.");

	// The global mask blocks every group request.
	AST_GLOBAL_MASK: assert property (@(posedge mclk) disable iff (rst)
		core_global_mask && !nmi_sync |=> !core_req)
		else $error("Group request passed the global mask.");

	// All level masks set block every group request.
	AST_LEVEL_MASK: assert property (@(posedge mclk) disable iff (rst)
		core_level_mask == 4'hF && !nmi_sync |=> !core_req)
		else $error("Group request passed the level masks.");

	// Without a pending group or non-maskable request the core sees nothing.
	AST_QUIET: assert property (@(posedge mclk) disable iff (rst)
		!nmi_sync && group_request == 64'h0000_0000_0000_0000 |=> !core_req)
		else $error("Core request raised with nothing pending.");

	// The selected level reaches the core one edge later.
	AST_LEVEL_OUT: assert property (@(posedge mclk) disable iff (rst)
		sel_valid && !nmi_sync |=> core_level == $past(sel_level))
		else $error("Core level differs from selected level.");

	// The non-maskable request carries no handler offset.
	AST_NMI_VEC: assert property (@(posedge mclk) disable iff (rst)
		nmi_sync |=> core_autovector == VEC_RESET)
		else $error("Non-maskable request carried a handler offset.");

	// The non-maskable flag drops once the request is gone.
	AST_NMI_FLAG: assert property (@(posedge mclk) disable iff (rst)
		!nmi_sync |=> !core_nmi)
		else $error("Non-maskable flag raised without a request.");
endmodule : grouped_intc
`default_nettype wire

// *** verif/core_source_model.sv ***
`default_nettype none
module core_source_model
	import intc_pkg::*;
(
	input  wire logic                 mclk,
	output var  logic [NUM_LINES-1:0] irq_lines,
	output var  logic                 nmi_req,
	output var  logic                 core_global_mask,
	output var  logic [3:0]           core_level_mask
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////
	// Peripherals and core start quiet with every level open.
	initial begin
		irq_lines        = '0;
		nmi_req          = 1'b0;
		core_global_mask = 1'b0;
		core_level_mask  = 4'h0;
	end

	// Sources change only just after an edge, as real flops would.
	task automatic set_line(input int n, input logic v);
		@(posedge mclk);
		irq_lines[n] <= v;
	endtask : set_line

	// The non-maskable source is a level like any other line.
	task automatic set_nmi(input logic v);
		@(posedge mclk);
		nmi_req <= v;
	endtask : set_nmi

	// Core status masks; a set bit blocks that level.
	task automatic set_mask(input logic g, input logic [3:0] lm);
		@(posedge mclk);
		core_global_mask <= g;
		core_level_mask  <= lm;
	endtask : set_mask
endmodule : core_source_model
`default_nettype wire

// *** verif/grouped_intc_bench.sv ***
`default_nettype none
module grouped_intc_bench
	import intc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 mclk, rst, read, write, waitrequest;
	logic                 nmi_req, core_global_mask, core_req, core_nmi;
	logic [ADDR_W-1:0]    address;
	logic [31:0]          writedata, readdata, rd;
	logic [3:0]           byteenable, core_level_mask;
	logic [NUM_LINES-1:0] irq_lines;
	logic [1:0]           core_level;
	logic [VEC_W-1:0]     core_autovector;
	int                   fails = 0, tests_run = 0, cycles = 0;

	grouped_intc DUT (.mclk(mclk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .irq_lines(irq_lines),
		.nmi_req(nmi_req), .core_global_mask(core_global_mask),
		.core_level_mask(core_level_mask), .core_req(core_req), .core_nmi(core_nmi),
		.core_level(core_level), .core_autovector(core_autovector));
	core_source_model src (.mclk(mclk), .irq_lines(irq_lines), .nmi_req(nmi_req),
		.core_global_mask(core_global_mask), .core_level_mask(core_level_mask));

	////////////////////////////////////////////////////////////
	// A 50 MHz clock and a cycle ceiling against hangs.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			tally_and_finish();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// Compares one value and reports a difference at once.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Packs the core outputs so they compare as one word.
	function automatic logic [31:0] cw(input logic r, input logic [1:0] l, input logic [13:0] v);
		return {15'h0, r, l, v};
	endfunction : cw

	// One bus access held until waitrequest is seen low at an edge.
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		address   <= a;
		write     <= wr;
		read      <= !wr;
		writedata <= wd;
		// The answer is judged at the rising edge itself, before the slave's flops move.
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0);
		check("answer", 32'h2, 32'(n));
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// Reads a word and compares it.
	task automatic reg_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask : reg_chk

	////////////////////////////////////////////////////////////
	// Priority words: reset value, stored fields, reserved bits dropped.
	task automatic t_prio();
		@(negedge mclk);
		check("idle wait", 32'h1, {31'h0, waitrequest});
		reg_chk(10'h038, 32'h0000_0000, "prio reset");
		bus(1'b1, 10'h038, 32'hBFFF_0100);
		reg_chk(10'h038, 32'h8000_0100, "prio14");
		bus(1'b1, 10'h010, 32'h8000_0040);
		bus(1'b1, 10'h064, 32'hC000_0200);
	endtask : t_prio

	// Request words, their latency to the core and their read-only nature.
	task automatic t_request();
		src.set_line(14 * 32 + 7, 1'b1);
		repeat (3) @(negedge mclk);
		check("core early", 32'h0, {31'h0, core_req});
		@(negedge mclk);
		check("core", cw(1'b1, 2'h2, 14'h0100), cw(core_req, core_level, core_autovector));
		reg_chk(10'h138, 32'h0000_0080, "req14");
		bus(1'b1, 10'h138, 32'h0000_0000);
		reg_chk(10'h138, 32'h0000_0080, "req14 kept");
		src.set_line(31 * 32, 1'b1);
		repeat (4) @(posedge mclk);
		reg_chk(10'h17C, 32'h0000_0000, "req31");
		reg_chk(10'h1FC, 32'h0000_0000, "req63");
		src.set_line(14 * 32 + 7, 1'b0);
		src.set_line(31 * 32, 1'b0);
		repeat (4) @(posedge mclk);
		reg_chk(10'h138, 32'h0000_0000, "req14 low");
		check("core idle", 32'h0, {31'h0, core_req});
	endtask : t_request

	// Cause words per level, lowest group wins, masking of levels.
	task automatic t_cause();
		src.set_line(14 * 32 + 3, 1'b1);
		src.set_line(4 * 32, 1'b1);
		repeat (5) @(posedge mclk);
		reg_chk(10'h204, 32'h0000_0004, "cause2");
		check("core g4", cw(1'b1, 2'h2, 14'h0040), cw(core_req, core_level, core_autovector));
		src.set_line(25 * 32 + 2, 1'b1);
		repeat (5) @(posedge mclk);
		reg_chk(10'h200, 32'h0000_0019, "cause3");
		check("core g25", cw(1'b1, 2'h3, 14'h0200), cw(core_req, core_level, core_autovector));
		src.set_mask(1'b0, 4'h8);
		repeat (5) @(posedge mclk);
		check("core lvl2", cw(1'b1, 2'h2, 14'h0040), cw(core_req, core_level, core_autovector));
		reg_chk(10'h200, 32'h0000_0019, "cause3 masked");
		src.set_mask(1'b1, 4'h0);
		repeat (5) @(posedge mclk);
		check("core global", 32'h0, {31'h0, core_req});
		src.set_mask(1'b0, 4'h0);
	endtask : t_cause

	// The non-maskable request overrides the level-3 group.
	task automatic t_nmi();
		src.set_nmi(1'b1);
		repeat (4) @(negedge mclk);
		check("nmi", cw(1'b1, 2'h3, 14'h0), cw(core_req, core_level, core_autovector));
		check("nmi flag", 32'h1, {31'h0, core_nmi});
		src.set_nmi(1'b0);
	endtask : t_nmi

	// Unmapped and read-only places.
	task automatic t_refuse();
		reg_chk(10'h210, 32'h0000_0000, "unmapped");
		bus(1'b1, 10'h204, 32'hFFFF_FFFF);
		reg_chk(10'h204, 32'h0000_0004, "cause2 kept");
		reg_chk(10'h20C, 32'h0000_0000, "cause0");
	endtask : t_refuse

	// Reset for six cycles, then every scenario in turn.
	initial begin
		rst        = 1'b1;
		read       = 1'b0;
		write      = 1'b0;
		address    = '0;
		writedata  = '0;
		byteenable = 4'hF;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_prio();
		t_request();
		t_cause();
		t_refuse();
		t_nmi();
		tally_and_finish();
	end
endmodule : grouped_intc_bench
`default_nettype wire
